//--- common/emz_pkg.sv
package emz_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] EMZ_OFS_DEEP_SLEEP  = 8'heb;
    localparam logic [7:0] EMZ_OFS_INPUT_MASK  = 8'hec;
    localparam logic [7:0] EMZ_OFS_MISC_MASK   = 8'hed;
    localparam logic [7:0] EMZ_OFS_ZONE1A      = 8'hee;
    localparam logic [7:0] EMZ_OFS_ZONE2A      = 8'hef;
    localparam logic [7:0] EMZ_RST_DEEP_SLEEP  = 8'h07;
    localparam logic [7:0] EMZ_RST_INPUT_MASK  = 8'hff;
    localparam logic [7:0] EMZ_RST_MISC_MASK   = 8'h3f;
    localparam logic [7:0] EMZ_RST_ZONE        = 8'h00;
    // writable bits per register; the rest are reserved and read zero
    localparam logic [7:0] EMZ_WMASK_DEEP      = 8'h0f;
    localparam logic [7:0] EMZ_WMASK_MISC      = 8'h3f;
    localparam logic [7:0] EMZ_WMASK_ZONE      = 8'h3f;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int EMZ_BIT_TEMP_DEEP = 3;
    localparam int EMZ_BIT_REG1_HOT  = 0;
    localparam int EMZ_BIT_REG2_HOT  = 1;
    localparam int EMZ_BIT_INPUT8    = 2;
    localparam int EMZ_BIT_INPUT9    = 3;
    localparam int EMZ_BIT_CPU1_DYN  = 4;
    localparam int EMZ_BIT_CPU2_DYN  = 5;
    localparam int EMZ_OFFSET_MSB    = 5;

    typedef enum logic [1:0] {
        EMZ_AWAKE,
        EMZ_SUSPEND_TO_RAM,
        EMZ_DEEPEST_SLEEP
    } emz_sleep_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } emz_bus_t;

    // raw error events from the measurement engine
    typedef struct packed {
        logic [2:0] analog12_14;
        logic [1:0] zone_temp;
        logic [1:0] zone_diode;
        logic [7:0] gpi;
        logic       general_input_eight;
        logic       general_input_nine;
        logic       regulator1_hot_event;
        logic       regulator2_hot_event;
        logic       cpu1_dyn;
        logic       cpu2_dyn;
    } emz_events_t;

    // lighter sleep-state masks held elsewhere
    typedef struct packed {
        logic [7:0] gpi;
        logic [3:0] analog_temp;
    } emz_str_mask_t;

    typedef struct packed {
        logic       valid;
        logic       zone2;
        logic [8:0] temp;
    } emz_meas_t;
endpackage : emz_pkg

//--- logic/emz_regs.sv
`timescale 1ns/1ps
// Operation
// RQ1 - in deepest sleep, mask bits 0..2 suppress analog 12, 13, 14 errors
// RQ2 - in deepest sleep, bit 3 suppresses zone 1/2 temperature and diode faults
// RQ3 - input mask bit n suppresses general input n error events
// RQ4 - input mask gates error status only; live pin state unaffected
// RQ5 - misc bits 0, 1 suppress regulator one and two hot events
// RQ6 - misc bits 2, 3 suppress general input eight and nine events
// RQ7 - misc bits 4, 5 suppress dynamic core-voltage events on analog 7, 8
// RQ8 - zone a offset is 6-bit two's complement added to each measurement
// RQ9 - downstream logic uses adjusted temperature as if truly measured
// RQ10 - offset spans +31 to -32 degrees, one degree per step
// RQ11 - suspend-to-ram masks apply only while in that state
// RQ12 - sleep state comes from an input; sleep masks apply only then
module emz_regs (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire emz_pkg::emz_bus_t      i_bus,
    input  wire emz_pkg::emz_sleep_t    i_sleep,
    input  wire emz_pkg::emz_events_t   i_events,
    input  wire emz_pkg::emz_str_mask_t i_str_mask,
    input  wire logic [7:0]             i_gpi_pins,
    input  wire emz_pkg::emz_meas_t     i_meas,
    output logic [7:0]                  o_rdata,
    output emz_pkg::emz_events_t        o_events,
    output logic [7:0]                  o_gpi_state,
    output emz_pkg::emz_meas_t          o_meas
);
    import emz_pkg::*;

    logic [7:0]  deep_sleep_analog_temp_mask_reg;
    logic [7:0]  input_pin_error_mask_reg;
    logic [7:0]  misc_event_mask_reg;
    logic [7:0]  first_zone_a_temp_offset_reg;
    logic [7:0]  second_zone_a_temp_offset_reg;
    logic [7:0]  gpi_meta_reg;
    logic [7:0]  gpi_sync_reg;
    logic [3:0]  sleep_mask;
    logic [7:0]  gpi_sleep_mask;
    logic [8:0]  offset_ext;
    logic [7:0]  zone_offset;
    emz_events_t events_next;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            deep_sleep_analog_temp_mask_reg <= EMZ_RST_DEEP_SLEEP;
            input_pin_error_mask_reg        <= EMZ_RST_INPUT_MASK;
            misc_event_mask_reg             <= EMZ_RST_MISC_MASK;
            first_zone_a_temp_offset_reg    <= EMZ_RST_ZONE;
            second_zone_a_temp_offset_reg   <= EMZ_RST_ZONE;
        end else if (i_bus.wr) begin
            unique case (i_bus.addr)
                EMZ_OFS_DEEP_SLEEP: begin
                    deep_sleep_analog_temp_mask_reg <= i_bus.wdata & EMZ_WMASK_DEEP;
                end
                EMZ_OFS_INPUT_MASK: begin
                    input_pin_error_mask_reg <= i_bus.wdata;
                end
                EMZ_OFS_MISC_MASK: begin
                    misc_event_mask_reg <= i_bus.wdata & EMZ_WMASK_MISC;
                end
                EMZ_OFS_ZONE1A: begin
                    first_zone_a_temp_offset_reg <= i_bus.wdata & EMZ_WMASK_ZONE;
                end
                EMZ_OFS_ZONE2A: begin
                    second_zone_a_temp_offset_reg <= i_bus.wdata & EMZ_WMASK_ZONE;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    // unmapped addresses read zero so this bank can be or-ed with its neighbours
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else begin
            unique case (i_bus.addr)
                EMZ_OFS_DEEP_SLEEP: o_rdata <= deep_sleep_analog_temp_mask_reg;
                EMZ_OFS_INPUT_MASK: o_rdata <= input_pin_error_mask_reg;
                EMZ_OFS_MISC_MASK:  o_rdata <= misc_event_mask_reg;
                EMZ_OFS_ZONE1A:     o_rdata <= first_zone_a_temp_offset_reg;
                EMZ_OFS_ZONE2A:     o_rdata <= second_zone_a_temp_offset_reg;
                default:            o_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // sleep-state mask selection
    // ----------------------------------------
    always_comb begin
        sleep_mask     = 4'h0;
        gpi_sleep_mask = 8'h00;
        unique case (i_sleep)
            EMZ_DEEPEST_SLEEP: begin
                sleep_mask = deep_sleep_analog_temp_mask_reg[3:0]; // RQ12
            end
            EMZ_SUSPEND_TO_RAM: begin
                sleep_mask     = i_str_mask.analog_temp; // RQ11
                gpi_sleep_mask = i_str_mask.gpi; // RQ11
            end
            default: begin
            end
        endcase
    end

    // ----------------------------------------
    // event gating
    // ----------------------------------------
    always_comb begin
        events_next             = i_events;
        events_next.analog12_14 = i_events.analog12_14 & ~sleep_mask[2:0]; // RQ1
        events_next.zone_temp   = i_events.zone_temp
                                  & ~{2{sleep_mask[EMZ_BIT_TEMP_DEEP]}}; // RQ2
        events_next.zone_diode  = i_events.zone_diode
                                  & ~{2{sleep_mask[EMZ_BIT_TEMP_DEEP]}}; // RQ2
        events_next.gpi         = i_events.gpi & ~input_pin_error_mask_reg
                                  & ~gpi_sleep_mask; // RQ3
        events_next.regulator1_hot_event = i_events.regulator1_hot_event
                                  & ~misc_event_mask_reg[EMZ_BIT_REG1_HOT]; // RQ5
        events_next.regulator2_hot_event = i_events.regulator2_hot_event
                                  & ~misc_event_mask_reg[EMZ_BIT_REG2_HOT]; // RQ5
        events_next.general_input_eight = i_events.general_input_eight
                                  & ~misc_event_mask_reg[EMZ_BIT_INPUT8]; // RQ6
        events_next.general_input_nine = i_events.general_input_nine
                                  & ~misc_event_mask_reg[EMZ_BIT_INPUT9]; // RQ6
        events_next.cpu1_dyn    = i_events.cpu1_dyn
                                  & ~misc_event_mask_reg[EMZ_BIT_CPU1_DYN]; // RQ7
        events_next.cpu2_dyn    = i_events.cpu2_dyn
                                  & ~misc_event_mask_reg[EMZ_BIT_CPU2_DYN]; // RQ7
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_events <= '0;
        end else begin
            o_events <= events_next;
        end
    end

    // ----------------------------------------
    // live pin state, never masked
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gpi_meta_reg <= 8'h00;
            gpi_sync_reg <= 8'h00;
            o_gpi_state  <= 8'h00;
        end else begin
            gpi_meta_reg <= i_gpi_pins;
            gpi_sync_reg <= gpi_meta_reg;
            o_gpi_state  <= gpi_sync_reg; // RQ4
        end
    end

    // ----------------------------------------
    // zone a offset adjust
    // ----------------------------------------
    // no saturation: the adjusted value wraps in 9 bits, a limitation software must respect
    assign zone_offset = i_meas.zone2 ? second_zone_a_temp_offset_reg
                                      : first_zone_a_temp_offset_reg;
    // whole degrees in the offset, measurement lsb is half a degree
    assign offset_ext  = {{2{zone_offset[EMZ_OFFSET_MSB]}},
                          zone_offset[EMZ_OFFSET_MSB:0], 1'b0}; // RQ10

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_meas <= '0;
        end else begin
            o_meas.valid <= i_meas.valid;
            o_meas.zone2 <= i_meas.zone2;
            o_meas.temp  <= i_meas.temp + offset_ext; // RQ8 RQ9
        end
    end
endmodule : emz_regs

//--- test/emz_regs_props.sv
`timescale 1ns/1ps
module emz_regs_props (
    input wire logic                   i_clk,
    input wire logic                   i_rst,
    input wire emz_pkg::emz_bus_t      i_bus,
    input wire emz_pkg::emz_sleep_t    i_sleep,
    input wire emz_pkg::emz_events_t   i_events,
    input wire emz_pkg::emz_str_mask_t i_str_mask,
    input wire logic [7:0]             i_gpi_pins,
    input wire emz_pkg::emz_meas_t     i_meas,
    input wire logic [7:0]             o_rdata,
    input wire emz_pkg::emz_events_t   o_events,
    input wire logic [7:0]             o_gpi_state,
    input wire emz_pkg::emz_meas_t     o_meas
);
    import emz_pkg::*;
    // ------
    // shadow bank: masks and zone offsets predicted from bus traffic alone
    // ------
    logic [7:0] sh [5];
    wire        hit = i_bus.addr >= EMZ_OFS_DEEP_SLEEP && i_bus.addr <= EMZ_OFS_ZONE2A;
    wire [2:0]  ix  = 3'(i_bus.addr - EMZ_OFS_DEEP_SLEEP);
    wire [7:0]  wm  = (ix == 3'h0) ? EMZ_WMASK_DEEP : (ix == 3'h1) ? 8'hff : EMZ_WMASK_ZONE;
    wire [7:0]  rd_exp = hit ? sh[ix] : 8'h00;
    wire        str = i_sleep == EMZ_SUSPEND_TO_RAM;
    wire [3:0]  am  = (i_sleep == EMZ_DEEPEST_SLEEP ? sh[0][3:0] : 4'h0)
                    | (str ? i_str_mask.analog_temp : 4'h0);
    wire [7:0]  gp_exp = i_events.gpi & ~sh[1] & ~(str ? i_str_mask.gpi : 8'h00);
    wire [2:0]  an_exp = i_events.analog12_14 & ~am[2:0];
    wire [3:0]  tz_exp = {i_events.zone_temp, i_events.zone_diode} & ~{4{am[3]}};
    wire [5:0]  mi_exp = i_events[5:0] & {~sh[2][2], ~sh[2][3], ~sh[2][0],
                                          ~sh[2][1], ~sh[2][4], ~sh[2][5]};
    wire [7:0]  ofs = i_meas.zone2 ? sh[4] : sh[3];
    wire [8:0]  ms_exp = i_meas.temp + {ofs[5], ofs[5], ofs[5:0], 1'b0};
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sh <= '{EMZ_RST_DEEP_SLEEP, EMZ_RST_INPUT_MASK, EMZ_RST_MISC_MASK,
                    EMZ_RST_ZONE, EMZ_RST_ZONE};
        end else if (i_bus.wr && hit) begin
            sh[ix] <= i_bus.wdata & wm;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence settled_3; !i_rst ##1 !i_rst ##1 !i_rst; endsequence
    read_back_a: assert property (!i_bus.wr |=> o_rdata == $past(rd_exp))
        else $error("read data differs from bank");
    gpi_mask_a: assert property (1'b1 |=> o_events.gpi == $past(gp_exp))
        else $error("input event mask wrong");
    analog_deep_a: assert property (1'b1 |=> o_events.analog12_14 == $past(an_exp))
        else $error("analog event mask wrong");
    temp_deep_a: assert property (1'b1 |=> {o_events.zone_temp, o_events.zone_diode} == $past(tz_exp))
        else $error("zone event mask wrong");
    misc_mask_a: assert property (1'b1 |=> o_events[5:0] == $past(mi_exp))
        else $error("misc event mask wrong");
    live_pins_a: assert property (settled_3 |=> o_gpi_state == $past(i_gpi_pins, 3))
        else $error("pin state not live");
    meas_adj_a: assert property (i_meas.valid |=> o_meas.temp == $past(ms_exp))
        else $error("offset not applied");
    meas_valid_a: assert property (!$past(i_rst) |-> o_meas.valid == $past(i_meas.valid))
        else $error("measurement strobe lost");
endmodule : emz_regs_props
bind emz_regs emz_regs_props emz_regs_props_inst (.i_clk, .i_rst, .i_bus, .i_sleep,
    .i_events, .i_str_mask, .i_gpi_pins, .i_meas, .o_rdata, .o_events, .o_gpi_state, .o_meas);

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import emz_pkg::*;
    logic          i_clk, i_rst;
    emz_bus_t      i_bus;
    emz_sleep_t    i_sleep;
    emz_events_t   i_events, o_events, ev;
    emz_str_mask_t i_str_mask;
    logic [7:0]    i_gpi_pins, o_rdata, o_gpi_state;
    emz_meas_t     i_meas, o_meas;
    int            fails = 0;
    int            check_count = 0;
    logic [7:0]    rv [5] = '{8'h07, 8'hff, 8'h3f, 8'h00, 8'h00};
    logic [7:0]    mv [5] = '{8'h0f, 8'hff, 8'h3f, 8'h3f, 8'h3f};
    logic [2:0]    an [3] = '{3'h7, 3'h6, 3'h5};
    emz_regs emz_regs_inst (.i_clk, .i_rst, .i_bus, .i_sleep, .i_events, .i_str_mask,
        .i_gpi_pins, .i_meas, .o_rdata, .o_events, .o_gpi_state, .o_meas);
    // ------
    // bus tasks and verdict
    // ------
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // two cycles per write so the strobe never toggles twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_bus <= '{1'b1, a, d};
        @(negedge i_clk);
        i_bus.wr <= 1'b0;
        @(negedge i_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_bus.addr <= a;
        @(negedge i_clk);
        chk(32'(o_rdata), 32'(e));
    endtask : rd
    task automatic end_sim;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #10us;
        fails++;
        end_sim();
    end
    initial begin
        i_rst = 1'b1;
        i_bus = '0;
        i_sleep = EMZ_AWAKE;
        i_events = '0;
        i_str_mask = '{8'h0f, 4'h9};
        i_gpi_pins = 8'h00;
        i_meas = '0;
        repeat (5) @(negedge i_clk);
        i_rst <= 1'b0;
        foreach (rv[k]) rd(8'heb + 8'(k), rv[k]);
        rd(8'hf0, 8'h00);
        foreach (mv[k]) wr(8'heb + 8'(k), 8'hff);
        foreach (mv[k]) rd(8'heb + 8'(k), mv[k]);
        wr(8'hf0, 8'hff);
        rd(8'hf0, 8'h00);
        wr(8'heb, 8'h0a);
        wr(8'hec, 8'h5a);
        wr(8'hed, 8'h15);
        wr(8'hee, 8'h1f);
        wr(8'hef, 8'h20);
        // all events raised; each sleep state selects a different mask set
        for (int s = 0; s < 3; s++) begin
            i_sleep <= emz_sleep_t'(s);
            i_events <= '1;
            @(negedge i_clk);
            ev = '1;
            ev.analog12_14 = an[s];
            {ev.zone_temp, ev.zone_diode} = (s == 0) ? 4'hf : 4'h0;
            ev.gpi = (s == 1) ? 8'ha0 : 8'ha5;
            ev[5:0] = 6'h15;
            chk(32'(o_events), 32'(ev));
        end
        i_gpi_pins <= 8'h3c;
        repeat (4) @(negedge i_clk);
        chk(32'(o_gpi_state), 32'h3c);
        i_meas <= '{1'b1, 1'b0, 9'h050};
        @(negedge i_clk);
        chk(32'(o_meas), {21'h0, 2'b10, 9'h08e});
        i_meas <= '{1'b1, 1'b1, 9'h050};
        @(negedge i_clk);
        chk(32'(o_meas), {21'h0, 2'b11, 9'h010});
        // second reset in mid-run: bank and outputs fall back to their reset state
        i_rst <= 1'b1;
        repeat (2) @(negedge i_clk);
        chk(32'(o_events), 32'h0);
        chk(32'(o_meas), 32'h0);
        i_rst <= 1'b0;
        foreach (rv[k]) rd(8'heb + 8'(k), rv[k]);
        end_sim();
    end
endmodule : tb_top
